//--- design/dp_exec_defs.vh
`ifndef DP_EXEC_DEFS_VH
`define DP_EXEC_DEFS_VH

// register word indices (byte address = 4 * index)
`define IDX_SRC_A      6'h00
`define IDX_SRC_B      6'h04
`define IDX_CTRL       6'h08
`define IDX_VCSR       6'h09
`define IDX_RES        6'h0C
`define IDX_STAT       6'h10

// control word fields
`define CTRL_OP_LSB    0
`define CTRL_IMM_LSB   8
`define VCSR_RM_LSB    0

// reset values
`define CTRL_RESET     32'h0000_0000
`define VCSR_RESET     32'h0000_0000

// rounding modes
`define RM_NEAR        2'h0
`define RM_DOWN        2'h1
`define RM_UP          2'h2
`define RM_ZERO        2'h3

// operation codes
`define OP_AND         5'h00
`define OP_ANDN        5'h01
`define OP_OR          5'h02
`define OP_XOR         5'h03
`define OP_PCMP        5'h04
`define OP_SCMP        5'h05
`define OP_OCMPF       5'h06
`define OP_UCMPF       5'h07
`define OP_SHUF        5'h08
`define OP_UNPH        5'h09
`define OP_UNPL        5'h0A
`define OP_PS2PD       5'h0B
`define OP_PD2PS       5'h0C
`define OP_SS2SD       5'h0D
`define OP_SD2SS       5'h0E
`define OP_PD2PI       5'h0F
`define OP_PD2PI_T     5'h10
`define OP_PI2PD       5'h11
`define OP_PD2DQ       5'h12
`define OP_PD2DQ_T     5'h13
`define OP_DQ2PD       5'h14
`define OP_SD2SI       5'h15
`define OP_SD2SI_T     5'h16
`define OP_SI2SD       5'h17
`define OP_PS2DQ       5'h18
`define OP_PS2DQ_T     5'h19
`define OP_DQ2PS       5'h1A

`define INT_INDEFINITE 32'h8000_0000
`define SGL_MAX_MAG    31'h7F7F_FFFF

`endif

//--- design/packed_double_logic_compare_convert.v
// Function
// - bitwise and, and-not, or, xor over both 128-bit operands
// - packed compare writes per-lane all-ones or all-zeros 64-bit mask
// - immediate picks one of twelve compare conditions
// - scalar mask compare uses low lanes, mask into low quadword
// - scalar ops pass first source high quadword through unchanged, except double-to-int converts, which zero bits 127:32
// - flag compares report result only through zero, parity, carry flags
// - ordered flag compare flags invalid on any not-a-number
// - unordered flag compare flags invalid only on signaling not-a-number
// - shuffle takes a first-source lane low, second-source lane high
// - high unpack interleaves both high lanes, first source low
// - low unpack interleaves both low lanes, first source low
// - widening single to double, packed two values and scalar one
// - narrowing double to single rounds with selected rounding mode
// - packed double to two signed 32-bit ints for 64-bit register
// - truncating variants round toward zero whatever the selected mode
// - two signed 32-bit ints from 64-bit source to two doubles
// - packed double to ints into low quadword of vector register
// - int to packed double reads the two low doublewords only
// - scalar double to signed 32-bit int for general register
// - signed 32-bit general register int to scalar double
// - four singles to four signed ints with mode rounding
// - four signed ints to four singles with mode rounding
//
// Added by the designer: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "dp_exec_defs.vh"

module packed_double_logic_compare_convert #(
    parameter AW = 8
) (
    input  wire          clk,
    input  wire          rstn,
    input  wire          psel,
    input  wire          penable,
    input  wire          pwrite,
    input  wire [AW-1:0] paddr,
    input  wire [31:0]   pwdata,
    output reg  [31:0]   prdata,
    output wire          pready,
    output wire          pslverr,
    output wire          zero_flag,
    output wire          parity_flag,
    output wire          carry_flag,
    output wire          invalid_op
);

    reg  [127:0] opa_q;
    reg  [127:0] opb_q;
    reg  [127:0] res_q;
    reg  [31:0]  ctrl_q;
    reg  [31:0]  vcsr_q;
    // {invalid, zero, parity, carry}
    reg  [3:0]   stat_q;
    reg  [127:0] res_d;
    reg  [2:0]   flags_d;
    reg          inv_d;
    reg  [2:0]   c0;
    reg  [2:0]   c1;
    reg  [31:0]  rd_mux;
    reg          hit;

    // word index; the two low address bits are ignored
    wire [5:0]   widx = paddr[7:2];
    wire         wr   = psel & penable & pwrite;
    wire [4:0]   op   = pwdata[`CTRL_OP_LSB +: 5];
    wire [7:0]   imm  = pwdata[`CTRL_IMM_LSB +: 8];
    wire [1:0]   rm   = vcsr_q[`VCSR_RM_LSB +: 2];
    wire [63:0]  a0   = opa_q[63:0];
    wire [63:0]  a1   = opa_q[127:64];
    wire [63:0]  b0   = opb_q[63:0];
    wire [63:0]  b1   = opb_q[127:64];

    // one strobe per writable group; result and status words take no writes
    wire         wr_opa    = wr & (widx[5:2] == 4'h0);
    wire         wr_opb    = wr & (widx[5:2] == 4'h1);
    wire         wr_vcsr   = wr & (widx == `IDX_VCSR);
    wire         wr_ctrl   = wr & (widx == `IDX_CTRL);
    wire         apb_setup = psel & ~penable;

    function rinc(input s, input l, input g, input st, input [1:0] m);
        begin
            case (m)
                `RM_NEAR: rinc = g & (st | l);
                `RM_DOWN: rinc = s & (g | st);
                `RM_UP:   rinc = ~s & (g | st);
                default:  rinc = 1'b0;
            endcase
        end
    endfunction

    function is_nan(input [63:0] x);
        begin
            is_nan = (x[62:52] == 11'h7FF) && (x[51:0] != 52'h0);
        end
    endfunction

    function is_signaling_not_a_number(input [63:0] x);
        begin
            is_signaling_not_a_number = is_nan(x) && !x[51];
        end
    endfunction

    // {unordered, less, equal}
    function [2:0] fcmp(input [63:0] a, input [63:0] b);
        reg [63:0] ka;
        reg [63:0] kb;
        reg        un;
        reg        eq;
        begin
            ka = a[63] ? ~a : {1'b1, a[62:0]};
            kb = b[63] ? ~b : {1'b1, b[62:0]};
            un = is_nan(a) | is_nan(b);
            eq = !un && ((a == b) || (a[62:0] == 63'h0 && b[62:0] == 63'h0));
            fcmp = {un, !un && !eq && (ka < kb), eq};
        end
    endfunction

    function pred(input [2:0] c, input [3:0] p);
        reg gt;
        begin
            gt = !c[2] && !c[1] && !c[0];
            case (p)
                4'h0:    pred = c[0];
                4'h1:    pred = c[1];
                4'h2:    pred = c[1] | c[0];
                4'h3:    pred = gt;
                4'h4:    pred = gt | c[0];
                4'h5:    pred = c[2];
                4'h6:    pred = !c[0];
                4'h7:    pred = !c[1];
                4'h8:    pred = !(c[1] | c[0]);
                4'h9:    pred = !gt;
                4'hA:    pred = !(gt | c[0]);
                4'hB:    pred = !c[2];
                default: pred = 1'b0;
            endcase
        end
    endfunction

    // relational predicates fault on any nan, the rest only on signaling
    function pinv(input [63:0] a, input [63:0] b, input [3:0] p);
        begin
            if (p == 4'h0 || p == 4'h5 || p == 4'h6 || p == 4'hB)
                pinv = is_signaling_not_a_number(a) | is_signaling_not_a_number(b);
            else
                pinv = is_nan(a) | is_nan(b);
        end
    endfunction

    // exact widening, denormals normalised
    function [63:0] s2d(input [31:0] x);
        reg [23:0] m;
        reg [10:0] e;
        integer    i;
        begin
            m = {1'b0, x[22:0]};
            e = 11'h381;
            if (x[30:23] == 8'hFF)
                s2d = {x[31], 11'h7FF, (x[22:0] != 23'h0) ? {1'b1, x[21:0]} : 23'h0, 29'h0};
            else if (x[30:23] != 8'h0)
                s2d = {x[31], {3'h0, x[30:23]} + 11'h380, x[22:0], 29'h0};
            else if (x[22:0] == 23'h0)
                s2d = {x[31], 63'h0};
            else begin
                for (i = 0; i < 23; i = i + 1) begin
                    if (!m[23]) begin
                        m = m << 1;
                        e = e - 11'h1;
                    end
                end
                s2d = {x[31], e, m[22:0], 29'h0};
            end
        end
    endfunction

    // exact: 32 bits always fit a double mantissa
    function [63:0] i2d(input [31:0] v);
        reg [31:0] a;
        reg [10:0] e;
        integer    i;
        begin
            a = v[31] ? (~v + 32'h1) : v;
            e = 11'h41E;
            if (v == 32'h0)
                i2d = 64'h0;
            else begin
                for (i = 0; i < 31; i = i + 1) begin
                    if (!a[31]) begin
                        a = a << 1;
                        e = e - 11'h1;
                    end
                end
                i2d = {v[31], e, a[30:0], 21'h0};
            end
        end
    endfunction

    function [31:0] d2s(input [63:0] x, input [1:0] m);
        reg [63:0] mm;
        reg [63:0] sv;
        reg [30:0] r;
        reg        g;
        reg        st;
        reg        inc;
        integer    se;
        integer    sh;
        begin
            se = x[62:52];
            se = se - 896;
            mm = {x[62:52] != 11'h0, x[51:0], 11'h0};
            sh = (se >= 1) ? 0 : (((1 - se) > 40) ? 41 : (1 - se));
            sv = mm >> sh;
            g  = sv[39];
            st = ((sv << sh) != mm) | (|sv[38:0]);
            inc = rinc(x[63], sv[40], g, st, m);
            r  = {(se >= 1) ? se[7:0] : 8'h0, sv[62:40]} + {30'h0, inc};
            if (is_nan(x))
                d2s = {x[63], 8'hFF, 1'b1, x[50:29]};
            else if (x[62:52] == 11'h7FF)
                d2s = {x[63], 8'hFF, 23'h0};
            else if (se >= 255 || r[30:23] == 8'hFF)
                d2s = (m == `RM_NEAR || (m == `RM_UP && !x[63]) || (m == `RM_DOWN && x[63]))
                    ? {x[63], 8'hFF, 23'h0} : {x[63], `SGL_MAX_MAG};
            else
                d2s = {x[63], r};
        end
    endfunction

    // out of range and nan give the integer indefinite value
    function [31:0] dtoi(input [63:0] x, input [1:0] m);
        reg [127:0] w;
        reg [63:0]  ip;
        reg         g;
        reg         st;
        reg         inc;
        integer     e;
        begin
            e  = x[62:52];
            ip = 64'h0;
            g  = 1'b0;
            st = |x[62:0];
            if (e >= 1022 && e <= 1085) begin
                w  = {1'b1, x[51:0], 75'h0} >> (1086 - e);
                ip = w[127:64];
                g  = w[63];
                st = |w[62:0];
            end
            inc = rinc(x[63], ip[0], g, st, m);
            ip  = ip + {63'h0, inc};
            if (e > 1085 || ip > (x[63] ? 64'h8000_0000 : 64'h7FFF_FFFF))
                dtoi = `INT_INDEFINITE;
            else
                dtoi = x[63] ? (~ip[31:0] + 32'h1) : ip[31:0];
        end
    endfunction

    // lane outcomes shared by the mask compares
    wire         mask_lo   = pred(c0, imm[3:0]);
    wire         mask_hi   = pred(c1, imm[3:0]);
    wire         inv_lo    = pinv(a0, b0, imm[3:0]);
    wire         inv_hi    = pinv(a1, b1, imm[3:0]);
    // {zero, parity, carry}: unordered 111, less 001, equal 100, greater 000
    wire [2:0]   cmp_flags = c0[2] ? 3'h7 : c0[1] ? 3'h1 : c0[0] ? 3'h4 : 3'h0;

    // result, flags and invalid of the operation named by the control word on the bus
    always @* begin
        c0      = fcmp(a0, b0);
        c1      = fcmp(a1, b1);
        res_d   = res_q;
        flags_d = stat_q[2:0];
        inv_d   = 1'b0;
        case (op)
            `OP_AND:  res_d = opa_q & opb_q;
            `OP_ANDN: res_d = ~opa_q & opb_q;
            `OP_OR:   res_d = opa_q | opb_q;
            `OP_XOR:  res_d = opa_q ^ opb_q;
            `OP_PCMP: begin
                res_d = {{64{mask_hi}}, {64{mask_lo}}};
                inv_d = inv_lo | inv_hi;
            end
            `OP_SCMP: begin
                res_d = {a1, {64{mask_lo}}};
                inv_d = inv_lo;
            end
            `OP_OCMPF, `OP_UCMPF: begin
                res_d   = res_q;
                flags_d = cmp_flags;
                if (op == `OP_OCMPF)
                    inv_d = is_nan(a0) | is_nan(b0);
                else
                    inv_d = is_signaling_not_a_number(a0) | is_signaling_not_a_number(b0);
            end
            `OP_SHUF: res_d = {imm[1] ? b1 : b0, imm[0] ? a1 : a0};
            `OP_UNPH: res_d = {b1, a1};
            `OP_UNPL: res_d = {b0, a0};
            `OP_PS2PD: res_d = {s2d(opb_q[63:32]), s2d(opb_q[31:0])};
            `OP_SS2SD: res_d = {a1, s2d(opb_q[31:0])};
            `OP_PD2PS: res_d = {64'h0, d2s(b1, rm), d2s(b0, rm)};
            `OP_SD2SS: res_d = {opa_q[127:32], d2s(b0, rm)};
            `OP_PD2PI: res_d = {64'h0, dtoi(b1, rm), dtoi(b0, rm)};
            `OP_PD2PI_T: res_d = {64'h0, dtoi(b1, `RM_ZERO), dtoi(b0, `RM_ZERO)};
            `OP_PI2PD: res_d = {i2d(opb_q[63:32]), i2d(opb_q[31:0])};
            `OP_PD2DQ: res_d = {64'h0, dtoi(b1, rm), dtoi(b0, rm)};
            `OP_PD2DQ_T: res_d = {64'h0, dtoi(b1, `RM_ZERO), dtoi(b0, `RM_ZERO)};
            `OP_DQ2PD: res_d = {i2d(opb_q[63:32]), i2d(opb_q[31:0])};
            `OP_SD2SI: res_d = {96'h0, dtoi(b0, rm)};
            `OP_SD2SI_T: res_d = {96'h0, dtoi(b0, `RM_ZERO)};
            `OP_SI2SD: res_d = {a1, i2d(opb_q[31:0])};
            `OP_PS2DQ: res_d = {dtoi(s2d(opb_q[127:96]), rm), dtoi(s2d(opb_q[95:64]), rm),
                                dtoi(s2d(opb_q[63:32]), rm), dtoi(s2d(opb_q[31:0]), rm)};
            `OP_PS2DQ_T: res_d = {dtoi(s2d(opb_q[127:96]), `RM_ZERO), dtoi(s2d(opb_q[95:64]), `RM_ZERO),
                                  dtoi(s2d(opb_q[63:32]), `RM_ZERO),
                                  dtoi(s2d(opb_q[31:0]), `RM_ZERO)};
            `OP_DQ2PS: res_d = {d2s(i2d(opb_q[127:96]), rm), d2s(i2d(opb_q[95:64]), rm),
                                d2s(i2d(opb_q[63:32]), rm), d2s(i2d(opb_q[31:0]), rm)};
            default: res_d = res_q;
        endcase
    end

    // read mux by word index; unmapped words read zero and raise the error
    always @* begin
        hit    = 1'b1;
        rd_mux = 32'h0;
        case (widx)
            6'h00, 6'h01, 6'h02, 6'h03: rd_mux = opa_q[{widx[1:0], 5'h0} +: 32];
            6'h04, 6'h05, 6'h06, 6'h07: rd_mux = opb_q[{widx[1:0], 5'h0} +: 32];
            `IDX_CTRL: rd_mux = ctrl_q;
            `IDX_VCSR: rd_mux = vcsr_q;
            6'h0C, 6'h0D, 6'h0E, 6'h0F: rd_mux = res_q[{widx[1:0], 5'h0} +: 32];
            `IDX_STAT: rd_mux = {28'h0, stat_q};
            default: hit = 1'b0;
        endcase
    end

    // no wait states: every access completes in its first access cycle
    assign pready      = 1'b1;
    assign pslverr     = psel & penable & ~hit;
    assign zero_flag   = stat_q[2];
    assign parity_flag = stat_q[1];
    assign carry_flag  = stat_q[0];
    assign invalid_op  = stat_q[3];

    always @(posedge clk) begin
        if (!rstn) begin
            opa_q  <= 128'h0;
            opb_q  <= 128'h0;
            res_q  <= 128'h0;
            ctrl_q <= `CTRL_RESET;
            vcsr_q <= `VCSR_RESET;
            stat_q <= 4'h0;
            prdata <= 32'h0;
        end else begin
            // read data captured in the setup cycle, valid in the access cycle
            if (apb_setup)
                prdata <= rd_mux;
            if (wr_opa)
                opa_q[{widx[1:0], 5'h0} +: 32] <= pwdata;
            if (wr_opb)
                opb_q[{widx[1:0], 5'h0} +: 32] <= pwdata;
            if (wr_vcsr)
                vcsr_q <= {30'h0, pwdata[`VCSR_RM_LSB +: 2]};
            // control write launches the operation on the stored operands
            if (wr_ctrl) begin
                ctrl_q <= {16'h0, imm, 3'h0, op};
                res_q  <= res_d;
                stat_q <= {inv_d, flags_d};
            end
        end
    end

endmodule

//--- sim/dp_exec_props.sv
`timescale 1ns/1ps
`include "dp_exec_defs.vh"

module dp_exec_props #(
    parameter AW = 8
) (
    input wire          clk,
    input wire          rstn,
    input wire          psel,
    input wire          penable,
    input wire          pwrite,
    input wire [AW-1:0] paddr,
    input wire [31:0]   pwdata,
    input wire [31:0]   prdata,
    input wire          pready,
    input wire          pslverr,
    input wire          zero_flag,
    input wire          parity_flag,
    input wire          carry_flag,
    input wire          invalid_op
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    wire          acc = psel && penable;
    wire [AW-3:0] idx = paddr[AW-1:2];
    wire          ctl_wr = acc && pwrite && idx == `IDX_CTRL;

    ready_high_a: assert property (acc |-> pready) else $error("access without ready");
    err_access_a: assert property (pslverr |-> acc) else $error("error outside access");
    err_unmapped_a: assert property (acc && idx == 6'h3F |-> pslverr) else $error("unmapped not flagged");
    err_mapped_a: assert property (acc && (idx == `IDX_CTRL || idx == `IDX_STAT) |-> !pslverr)
        else $error("mapped access flagged");
    rd_unmapped_a: assert property (acc && !pwrite && pslverr |-> prdata == 32'h0) else $error("unmapped read data");
    stat_read_a: assert property (acc && !pwrite && idx == `IDX_STAT |->
        prdata == {28'h0, invalid_op, zero_flag, parity_flag, carry_flag}) else $error("status word mismatch");
    flag_code_a: assert property ((zero_flag && carry_flag) == parity_flag) else $error("flag pattern");
    flags_hold_a: assert property (!ctl_wr |=> $stable({zero_flag, parity_flag, carry_flag, invalid_op}))
        else $error("flags moved without execute");
    other_keep_a: assert property (ctl_wr && pwdata[4:0] != `OP_OCMPF && pwdata[4:0] != `OP_UCMPF
        |=> $stable({zero_flag, parity_flag, carry_flag})) else $error("flags moved by other op");
    reset_clear_a: assert property ($rose(rstn) |-> !zero_flag && !parity_flag && !carry_flag && !invalid_op)
        else $error("flags not cleared by reset");
endmodule

bind packed_double_logic_compare_convert dp_exec_props #(.AW(AW)) u_props (
    .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .zero_flag(zero_flag),
    .parity_flag(parity_flag), .carry_flag(carry_flag), .invalid_op(invalid_op));

//--- sim/apb_host.sv
`timescale 1ns/1ps

module apb_host #(
    parameter AW = 8
) (
    input  wire           clk,
    output logic          psel,
    output logic          penable,
    output logic          pwrite,
    output logic [AW-1:0] paddr,
    output logic [31:0]   pwdata,
    input  wire  [31:0]   prdata,
    input  wire           pready,
    input  wire           pslverr
);
    initial {psel, penable, pwrite, paddr, pwdata} = '0;

    // one transfer; request held until ready is seen at a rising edge
    task xfer(input logic w, input logic [AW-1:0] a, input logic [31:0] wd, output logic [31:0] rdat,
              output logic err);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rdat = prdata;
        err  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule

//--- sim/tb_packed_double_logic_compare_convert.sv
`timescale 1ns/1ps
`include "dp_exec_defs.vh"

module tb_packed_double_logic_compare_convert;
    localparam logic [127:0] A_V = 128'h7FF8000000000000_3FF0000000000000;
    localparam logic [63:0]  AH  = 64'h7FF8000000000000;
    localparam logic [63:0]  BH  = 64'h3F800000_40000000;
    localparam logic [63:0]  ONE = 64'h3FF0000000000000;
    localparam logic [63:0]  TWO = 64'h4000000000000000;
    localparam logic [63:0]  MID = 64'h3FF0000010400000;
    localparam logic [63:0]  P25 = 64'h4004000000000000;
    localparam logic [63:0]  M25 = 64'hC004000000000000;
    localparam logic [63:0]  I2  = 64'hFFFFFFFF_00000002;
    localparam logic [63:0]  S25 = 64'hC0200000_40200000;

    logic         clk  = 1'b0;
    logic         rstn = 1'b0;
    wire          psel, penable, pwrite, pready, pslverr;
    wire  [7:0]   paddr;
    wire  [31:0]  pwdata, prdata;
    wire          zero_flag, parity_flag, carry_flag, invalid_op;
    logic [127:0] r, q;
    logic [31:0]  d;
    logic         e;
    int           n_mismatch = 0;
    int           n_tests = 0;

    always #2 clk = ~clk;

    apb_host u_host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
                     .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    packed_double_logic_compare_convert dut (
        .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .zero_flag(zero_flag),
        .parity_flag(parity_flag), .carry_flag(carry_flag), .invalid_op(invalid_op));

    task chk(input logic [127:0] got, input logic [127:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task wr(input logic [5:0] i, input logic [31:0] v);
        u_host.xfer(1'b1, {i, 2'h0}, v, d, e);
    endtask

    task rd(input logic [5:0] i);
        u_host.xfer(1'b0, {i, 2'h0}, 32'h0, d, e);
    endtask

    task ld(input logic [127:0] a, input logic [127:0] b);
        for (int k = 0; k < 4; k++) begin
            wr(`IDX_SRC_A + 6'(k), a[32 * k +: 32]);
            wr(`IDX_SRC_B + 6'(k), b[32 * k +: 32]);
        end
    endtask

    // execute, then fetch the 128-bit result into r
    task ex(input logic [4:0] op, input logic [7:0] imm, input logic [1:0] rm);
        wr(`IDX_VCSR, {30'h0, rm});
        wr(`IDX_CTRL, {16'h0, imm, 3'h0, op});
        for (int k = 0; k < 4; k++) begin
            rd(`IDX_RES + 6'(k));
            r[32 * k +: 32] = d;
        end
    endtask

    task t_regs;
        rd(`IDX_CTRL);
        chk(128'(d), 128'(`CTRL_RESET));
        rd(6'h3F);
        chk(128'({d, e}), 128'h1);
        wr(`IDX_RES, 32'h1234_5678);
        ex(5'h1B, 8'hAB, 2'h3);
        chk(r, 128'h0);
        rd(`IDX_CTRL);
        chk(128'(d), 128'hAB1B);
        rd(`IDX_VCSR);
        chk(128'(d), 128'h3);
    endtask

    task t_logic;
        q = {BH, TWO};
        ld(A_V, q);
        for (int op = 0; op < 4; op++) begin
            ex(5'(op), 8'h00, 2'h0);
            chk(r, op == 0 ? A_V & q : op == 1 ? ~A_V & q : op == 2 ? A_V | q : A_V ^ q);
        end
    endtask

    // low lane is less-than, high lane is unordered; bit p is predicate p
    task t_cmp;
        logic [12:0] lt_t;
        logic [12:0] un_t;
        logic [12:0] inv_t;
        lt_t = 13'h0E46;
        un_t = 13'h07E0;
        inv_t = 13'h179E;
        ld(A_V, {TWO, TWO});
        for (int p = 0; p < 13; p++) begin
            ex(`OP_PCMP, 8'(p), 2'h0);
            chk(r, {{64{un_t[p]}}, {64{lt_t[p]}}});
            chk(128'(invalid_op), 128'(inv_t[p]));
            ex(`OP_SCMP, 8'(p), 2'h0);
            chk(r, {AH, {64{lt_t[p]}}});
            chk(128'(invalid_op), 128'h0);
        end
    endtask

    task fc(input logic [63:0] a, input logic [4:0] op, input logic [3:0] x);
        q = r;
        ld({TWO, a}, {TWO, TWO});
        ex(op, 8'h00, 2'h0);
        chk(r, q);
        rd(`IDX_STAT);
        chk(128'({d[3:0], invalid_op, zero_flag, parity_flag, carry_flag}), 128'({x, x}));
    endtask

    task t_flag;
        fc(ONE, `OP_OCMPF, 4'h1);
        fc(64'h4008000000000000, `OP_UCMPF, 4'h0);
        fc(TWO, `OP_OCMPF, 4'h4);
        fc(AH, `OP_OCMPF, 4'hF);
        fc(AH, `OP_UCMPF, 4'h7);
        fc(64'h7FF4000000000000, `OP_UCMPF, 4'hF);
    endtask

    task t_shuf;
        q = {BH, TWO};
        ld(A_V, q);
        for (int i = 0; i < 4; i++) begin
            ex(`OP_SHUF, 8'(i), 2'h0);
            chk(r, {q[64 * i[1] +: 64], A_V[64 * i[0] +: 64]});
        end
        ex(`OP_UNPH, 8'h00, 2'h0);
        chk(r, {BH, AH});
        ex(`OP_UNPL, 8'h00, 2'h0);
        chk(r, {TWO, ONE});
    endtask

    task cv(input logic [4:0] op, input logic [1:0] rm, input logic [63:0] b, input logic [127:0] x);
        ld(A_V, {BH, b});
        ex(op, 8'h00, rm);
        chk(r, x);
    endtask

    // upper source lane BH: singles 1.0 and 2.0, or a small positive double
    task t_conv;
        cv(`OP_PS2PD, 2'h0, 64'h40000000_3F800000, {TWO, ONE});
        cv(`OP_SS2SD, 2'h0, 64'h40000000_3F800000, {AH, ONE});
        cv(`OP_PD2PS, 2'h0, MID, 128'h3C000002_3F800001);
        cv(`OP_PD2PS, 2'h1, MID, 128'h3C000002_3F800000);
        cv(`OP_SD2SS, 2'h2, MID, {AH, 64'h3FF00000_3F800001});
        cv(`OP_PD2PI, 2'h1, M25, 128'hFFFFFFFD);
        cv(`OP_PD2PI_T, 2'h1, M25, 128'hFFFFFFFE);
        cv(`OP_PD2DQ, 2'h2, P25, 128'h00000001_00000003);
        cv(`OP_PD2DQ_T, 2'h2, P25, 128'h2);
        cv(`OP_SD2SI, 2'h2, P25, 128'h3);
        cv(`OP_SD2SI_T, 2'h2, P25, 128'h2);
        cv(`OP_PI2PD, 2'h0, I2, {64'hBFF0000000000000, TWO});
        cv(`OP_DQ2PD, 2'h0, I2, {64'hBFF0000000000000, TWO});
        cv(`OP_SI2SD, 2'h0, I2, {AH, TWO});
        cv(`OP_PS2DQ, 2'h1, S25, 128'h00000001_00000002_FFFFFFFD_00000002);
        cv(`OP_PS2DQ_T, 2'h1, S25, 128'h00000001_00000002_FFFFFFFE_00000002);
        cv(`OP_DQ2PS, 2'h2, 64'hFFFFFFFF_01000001, 128'h4E7E0000_4E800000_BF800000_4B800001);
    endtask

    task tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial begin
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        t_regs;
        t_logic;
        t_cmp;
        t_flag;
        t_shuf;
        t_conv;
        tally_and_finish;
    end

    initial begin
        #100000;
        n_mismatch++;
        tally_and_finish;
    end
endmodule
